// [common/squib_consts.vh]
// Constants of the squib driver serial command front end
// Notes on behaviour
// [RULE1] One byte per frame, MSB first
// [RULE2] Reply carries previous frame's selected result
// [RULE3] No-op clears diagnostics, echoes shift contents
// [RULE4] Undefined byte clears diagnostics, echoes contents
// [RULE5] Command acts when chip select rises
// [RULE6] Next valid command cancels active diagnostic
// [RULE7] Byte 0x96 answers 0x69 next frame
// [RULE8] Unused reply bits read zero
// [RULE9] Only exactly eight-bit frames are accepted
// [RULE10] Fire byte is no-op while driving
// [RULE11] Arm and fire must be consecutive frames
// [RULE12] Sample on rising, change on falling
// [RULE13] Clock level at select fall picks mode
// [RULE14] Data output floats while deselected
// [RULE15] Status reply bit seven names variant
// [RULE16] Continuity command reports channels next frame
// [RULE17] Continuity result held until next valid command
// [RULE18] Host enables low side before high; the device itself switches each low side on one cycle ahead of its high side
// [RULE19] Firing needs arm, fire and enable
// [RULE20] Enable one gates 1A/1B, two 2A/2B
// [RULE21] Arm pair one, pair two, or all
// [RULE22] Arm and fire bytes echoed back
// [RULE23] Force loop shorts, partner senses 0xE8
// [RULE24] Fire upper nibble must pair with arm
// [RULE25] Enable low stops drivers unless held
// [RULE26] Reset clears state and shift registers
// [RULE27] Select fall loads pending result
// [RULE28] Fired drivers stay on until cleared
`ifndef SQUIB_CONSTS_VH
`define SQUIB_CONSTS_VH

// Frame length and bit counter ceiling
`define FRAME_BITS 4'h8
`define CNT_SAT 4'h9
`define CNT_ZERO 4'h0
`define CNT_ONE 4'h1

// Command codes
`define CMD_NOP 8'h00
`define CMD_ECHO 8'h96
`define ECHO_REPLY 8'h69
`define CMD_STATUS 8'hc8
`define CMD_CONT 8'hc2
`define CMD_LOOP_SENSE 8'he8
`define LOOP_FORCE_TOP 6'h38
`define ARM_NIBBLE 4'ha
`define FIRE_NIBBLE 4'h5
`define ARM_ONE 4'h0
`define ARM_TWO 4'h1
`define ARM_ALL 4'h2

// Channel masks, bit 0 is 1A, bit 3 is 2B
`define MASK_PAIR_ONE 4'h3
`define MASK_PAIR_TWO 4'hc
`define MASK_NONE 4'h0

// Reset values
`define BYTE_ZERO 8'h00
`define SYNC_RST 15'h0002

`endif

// [rtl/bit_sync.v]
// Two-stage synchroniser for signals from outside the clock domain
`timescale 1ns/10ps
module bit_sync #(
    parameter W = 1,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
    input wire sys_clk_i,
    input wire rst_n_i,
    input wire [W-1:0] async_i,
    output wire [W-1:0] sync_o
);
    reg [W-1:0] meta_r;
    reg [W-1:0] sync_r;

    // First stage feeds only the second stage
    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            meta_r <= RST_VAL;
            sync_r <= RST_VAL;
        end else begin
            meta_r <= async_i;
            sync_r <= meta_r;
        end
    end

    assign sync_o = sync_r;
endmodule

// [rtl/squib_fire_control.v]
// Arm and fire sequencing with enable gating of the squib drivers
`timescale 1ns/10ps
`include "squib_consts.vh"
module squib_fire_control (
    input wire sys_clk_i,
    input wire rst_n_i,
    input wire exec_i,
    input wire is_arm_i,
    input wire [7:0] cmd_i,
    input wire fen_one_i,
    input wire fen_two_i,
    input wire latch_hold_i,
    input wire thermal_i,
    output wire [3:0] high_drv_o,
    output wire [3:0] low_drv_o
);
    reg arm_pend_r;
    reg [3:0] arm_top_r;
    reg [3:0] armed_r;
    reg [3:0] fire_r;
    reg [3:0] low_r;
    reg [3:0] high_r;
    reg [3:0] arm_mask;
    wire [3:0] gate;
    wire [3:0] drive;

    // Pairs allowed by their enable inputs
    assign gate = {fen_two_i, fen_two_i, fen_one_i, fen_one_i}; // [RULE20]
    assign drive = fire_r & (gate | {4{latch_hold_i}}); // [RULE25]

    // Channels the arm byte prepares
    always @* begin
        case (cmd_i[3:0])
            `ARM_ONE: arm_mask = `MASK_PAIR_ONE; // [RULE21]
            `ARM_TWO: arm_mask = `MASK_PAIR_TWO;
            `ARM_ALL: arm_mask = `MASK_PAIR_ONE | `MASK_PAIR_TWO;
            default: arm_mask = `MASK_NONE;
        endcase
    end

    // Arm, then fire on the very next valid frame
    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin // [RULE26]
            arm_pend_r <= 1'b0;
            arm_top_r <= 4'h0;
            armed_r <= `MASK_NONE;
            fire_r <= `MASK_NONE;
        end else begin
            if (thermal_i) begin
                fire_r <= `MASK_NONE; // [RULE28]
            end else if (exec_i && !is_arm_i && arm_pend_r &&
                         cmd_i[7:4] == ~arm_top_r && // [RULE24]
                         !(|low_r)) begin // [RULE10]
                fire_r <= (fire_r & ~armed_r) |
                          (cmd_i[3:0] & armed_r); // [RULE19]
            end
            if (exec_i) begin
                arm_pend_r <= is_arm_i; // [RULE11]
                if (is_arm_i) begin
                    arm_top_r <= cmd_i[7:4];
                    armed_r <= arm_mask & gate; // [RULE20]
                end
            end
        end
    end

    // Low side switches on one cycle ahead of high side
    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            low_r <= `MASK_NONE;
            high_r <= `MASK_NONE;
        end else begin
            low_r <= drive;
            high_r <= drive & low_r; // [RULE18]
        end
    end

    assign high_drv_o = high_r;
    assign low_drv_o = low_r;
endmodule

// [rtl/squib_spi_command_interface.v]
// Serial command front end of a four-channel squib driver
`timescale 1ns/10ps
`include "squib_consts.vh"
module squib_spi_command_interface (
    input wire sys_clk_i,
    input wire rst_n_i,
    input wire sclk_i,
    input wire cs_n_i,
    input wire mosi_i,
    input wire fire_enable_pair_one_i,
    input wire fire_enable_pair_two_i,
    input wire [3:0] low_side_continuity_check_i,
    input wire [3:0] loop_short_sense_i,
    input wire thermal_shutdown_i,
    input wire latch_hold_i,
    input wire two_channel_strap_i,
    output wire serial_data_output_o,
    output wire serial_data_output_oe_n_o,
    output wire alternate_serial_mode_o,
    output wire [3:0] squib_high_pin_o,
    output wire [3:0] squib_low_pin_o,
    output wire continuity_test_o,
    output wire loop_force_en_o,
    output wire [1:0] loop_force_sel_o,
    output wire loop_sense_en_o,
    output wire frame_reject_o
);
    // Frame states
    localparam ST_IDLE = 1'b0;
    localparam ST_FRAME = 1'b1;

    // Synchronised pins
    wire [14:0] pins_s;
    wire sclk_s;
    wire cs_s;
    wire mosi_s;
    wire fen_one_s;
    wire fen_two_s;
    wire [3:0] cont_s;
    wire [3:0] loop_s;
    wire thermal_s;
    wire hold_s;

    // Edge detection
    reg sclk_d_r;
    reg cs_d_r;
    wire sclk_rise;
    wire sclk_fall;
    wire cs_fall;
    wire cs_rise;

    // Frame engine
    reg st_r;
    reg st_nxt;
    reg [3:0] cnt_r;
    reg [7:0] rx_r;
    reg [7:0] tx_r;
    reg [7:0] resp_r;
    reg alt_r;
    reg miso_r;
    reg oe_n_r;
    reg reject_r;
    reg id_r;
    reg strap_meta_r;
    wire frame_ok;

    // Diagnostic modes and their next values
    reg cont_r;
    reg force_r;
    reg sense_r;
    reg [1:0] sel_r;
    reg [7:0] resp_nxt;
    reg cont_nxt;
    reg force_nxt;
    reg sense_nxt;
    reg [1:0] sel_nxt;

    // Results gathered between frames
    reg [3:0] cont_lat_r;
    reg [3:0] sense_lat_r;

    // Strobes to the firing logic
    reg exec_r;
    reg arm_r;
    reg [7:0] cmd_r;

    // Arm byte decode
    function is_arm;
        input [7:0] b;
        begin
            is_arm = (b[7:4] == `ARM_NIBBLE) &&
                     (b[3:0] == `ARM_ONE || b[3:0] == `ARM_TWO ||
                      b[3:0] == `ARM_ALL);
        end
    endfunction

    // Fire byte decode
    function is_fire;
        input [7:0] b;
        begin
            is_fire = (b[7:4] == `FIRE_NIBBLE);
        end
    endfunction

    // Loop-to-loop forcing byte decode
    function is_force;
        input [7:0] b;
        begin
            is_force = (b[7:2] == `LOOP_FORCE_TOP);
        end
    endfunction

    // All pins from outside pass two flip-flops
    bit_sync #(
        .W(15),
        .RST_VAL(`SYNC_RST)
    ) u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .async_i({hold_s_in(latch_hold_i), thermal_shutdown_i,
                  loop_short_sense_i, low_side_continuity_check_i,
                  fire_enable_pair_two_i, fire_enable_pair_one_i,
                  mosi_i, cs_n_i, sclk_i}),
        .sync_o(pins_s)
    );

    // Name the synchronised bits
    assign sclk_s = pins_s[0];
    assign cs_s = pins_s[1];
    assign mosi_s = pins_s[2];
    assign fen_one_s = pins_s[3];
    assign fen_two_s = pins_s[4];
    assign cont_s = pins_s[8:5];
    assign loop_s = pins_s[12:9];
    assign thermal_s = pins_s[13];
    assign hold_s = pins_s[14];

    // Pass-through helper keeps the concatenation readable
    function hold_s_in;
        input b;
        begin
            hold_s_in = b;
        end
    endfunction

    // Delayed copies for edge detection
    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            sclk_d_r <= 1'b0;
            cs_d_r <= 1'b1;
        end else begin
            sclk_d_r <= sclk_s;
            cs_d_r <= cs_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_d_r;
    assign sclk_fall = ~sclk_s & sclk_d_r;
    assign cs_fall = ~cs_s & cs_d_r;
    assign cs_rise = cs_s & ~cs_d_r;

    // Exactly eight rising edges make a valid frame
    assign frame_ok = (st_r == ST_FRAME) && cs_rise &&
                      (cnt_r == `FRAME_BITS); // [RULE9]

    // Frame state follows chip select
    always @* begin
        case (st_r)
            ST_IDLE: st_nxt = cs_fall ? ST_FRAME : ST_IDLE;
            ST_FRAME: st_nxt = cs_rise ? ST_IDLE : ST_FRAME;
            default: st_nxt = ST_IDLE;
        endcase
    end

    // Strap caught while reset is held
    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            strap_meta_r <= two_channel_strap_i;
            id_r <= strap_meta_r; // [RULE15]
        end
    end

    // State, bit counter and mode capture
    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            st_r <= ST_IDLE;
            cnt_r <= `CNT_ZERO;
            alt_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            if (cs_fall) begin
                cnt_r <= `CNT_ZERO;
                alt_r <= sclk_s; // [RULE13]
            end else if (st_r == ST_FRAME && sclk_rise &&
                         cnt_r != `CNT_SAT) begin
                cnt_r <= cnt_r + `CNT_ONE; // [RULE9]
            end
        end
    end

    // Receive shift register, sampled on rising clock
    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            rx_r <= `BYTE_ZERO; // [RULE26]
        end else if (cs_fall) begin
            rx_r <= `BYTE_ZERO;
        end else if (st_r == ST_FRAME && sclk_rise) begin
            rx_r <= {rx_r[6:0], mosi_s}; // [RULE1] [RULE12]
        end
    end

    // Transmit shift register, moves on falling clock
    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            tx_r <= `BYTE_ZERO; // [RULE26]
        end else if (cs_fall && cont_r) begin
            // Pending continuity result replaces the stored reply
            tx_r <= {`MASK_NONE, cont_lat_r}; // [RULE27] [RULE16] [RULE8]
        end else if (cs_fall && sense_r) begin
            tx_r <= {`MASK_NONE, sense_lat_r}; // [RULE27] [RULE23] [RULE8]
        end else if (cs_fall) begin
            tx_r <= resp_r; // [RULE27] [RULE2]
        end else if (st_r == ST_FRAME && sclk_fall &&
                     cnt_r != `CNT_ZERO) begin
            // Idle-high clock gives no shift before first sample
            tx_r <= {tx_r[6:0], 1'b0}; // [RULE1] [RULE12]
        end
    end

    // Output pin and its enable
    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            miso_r <= 1'b0;
            oe_n_r <= 1'b1;
        end else begin
            miso_r <= tx_r[7] & ~cs_s;
            oe_n_r <= cs_s; // [RULE14]
        end
    end

    // Decode the received byte into reply and modes
    always @* begin
        resp_nxt = rx_r; // [RULE3] [RULE4] [RULE22]
        cont_nxt = 1'b0; // [RULE6]
        force_nxt = 1'b0;
        sense_nxt = 1'b0;
        sel_nxt = 2'h0;
        if (rx_r == `CMD_ECHO) begin
            resp_nxt = `ECHO_REPLY; // [RULE7]
        end else if (rx_r == `CMD_STATUS) begin
            // Variant bit on top, enable levels at the bottom
            resp_nxt = {id_r, 5'h00, fen_two_s, fen_one_s}; // [RULE15]
        end else if (rx_r == `CMD_CONT) begin
            cont_nxt = 1'b1;
            resp_nxt = `BYTE_ZERO; // [RULE16] Latch supplies the reply
        end else if (is_force(rx_r)) begin
            force_nxt = 1'b1;
            sel_nxt = rx_r[1:0]; // [RULE23]
            resp_nxt = `BYTE_ZERO; // [RULE8]
        end else if (rx_r == `CMD_LOOP_SENSE) begin
            sense_nxt = 1'b1;
            resp_nxt = `BYTE_ZERO; // [RULE23] Latch supplies the reply
        end else if (is_arm(rx_r) || is_fire(rx_r)) begin
            resp_nxt = rx_r; // [RULE22]
        end
    end

    // Commands take effect at the end of a valid frame
    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            resp_r <= `BYTE_ZERO;
            cont_r <= 1'b0;
            force_r <= 1'b0;
            sense_r <= 1'b0;
            sel_r <= 2'h0;
            reject_r <= 1'b0;
        end else begin
            reject_r <= (st_r == ST_FRAME) && cs_rise && !frame_ok;
            if (frame_ok) begin // [RULE5]
                // Reply is replaced in the same cycle that frame_ok clears the continuity latch
                resp_r <= resp_nxt; // [RULE17] [RULE2]
                cont_r <= cont_nxt; // [RULE6] [RULE3] [RULE4]
                force_r <= force_nxt;
                sense_r <= sense_nxt;
                sel_r <= sel_nxt;
            end
        end
    end

    // Diagnostic results gathered while a test mode runs
    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            cont_lat_r <= `MASK_NONE; // [RULE26]
            sense_lat_r <= `MASK_NONE;
        end else if (frame_ok) begin
            // Cleared as the next valid frame ends
            cont_lat_r <= `MASK_NONE; // [RULE17]
            sense_lat_r <= `MASK_NONE;
        end else begin
            if (cont_r) begin
                cont_lat_r <= cont_lat_r | cont_s; // [RULE16] [RULE17]
            end
            if (sense_r) begin
                sense_lat_r <= loop_s; // [RULE23]
            end
        end
    end

    // One-cycle execute strobe for the firing logic
    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            exec_r <= 1'b0;
            arm_r <= 1'b0;
            cmd_r <= `BYTE_ZERO;
        end else begin
            exec_r <= frame_ok; // [RULE5]
            if (frame_ok) begin
                arm_r <= is_arm(rx_r); // [RULE19]
                cmd_r <= rx_r;
            end
        end
    end

    // Arm and fire sequencing with enable gating
    squib_fire_control u_fire (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .exec_i(exec_r),
        .is_arm_i(arm_r),
        .cmd_i(cmd_r),
        .fen_one_i(fen_one_s),
        .fen_two_i(fen_two_s),
        .latch_hold_i(hold_s),
        .thermal_i(thermal_s),
        .high_drv_o(squib_high_pin_o),
        .low_drv_o(squib_low_pin_o)
    );

    // Outputs straight from flip-flops
    assign serial_data_output_o = miso_r;
    assign serial_data_output_oe_n_o = oe_n_r;
    assign alternate_serial_mode_o = alt_r;
    assign continuity_test_o = cont_r;
    assign loop_force_en_o = force_r;
    assign loop_force_sel_o = sel_r;
    assign loop_sense_en_o = sense_r;
    assign frame_reject_o = reject_r;
endmodule

// [tb/squib_spi_command_interface_properties.sv]
// Port checks for the squib serial command front end
`timescale 1ns/10ps
module squib_checker (
    input wire sys_clk_i,
    input wire rst_n_i,
    input wire cs_n_i,
    input wire fire_enable_pair_one_i,
    input wire latch_hold_i,
    input wire thermal_shutdown_i,
    input wire serial_data_output_o,
    input wire serial_data_output_oe_n_o,
    input wire alternate_serial_mode_o,
    input wire [3:0] squib_high_pin_o,
    input wire [3:0] squib_low_pin_o,
    input wire continuity_test_o,
    input wire loop_force_en_o,
    input wire loop_sense_en_o,
    input wire frame_reject_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    a_idle_float: assert property (cs_n_i [*6] |-> serial_data_output_oe_n_o)
        else $error("data output driven while deselected");
    a_idle_zero: assert property (serial_data_output_oe_n_o |-> !serial_data_output_o)
        else $error("data output not zero while floating");
    a_reject_pulse: assert property (frame_reject_o |=> !frame_reject_o)
        else $error("reject pulse longer than one cycle");
    a_reject_idle: assert property (frame_reject_o |-> cs_n_i && $past(cs_n_i, 2))
        else $error("reject raised inside a frame");
    a_mode_select: assert property ($changed(alternate_serial_mode_o)
        |-> !cs_n_i && $past(cs_n_i, 6))
        else $error("mode changed away from select fall");
    a_diag_at_end: assert property ($changed({continuity_test_o,
        loop_force_en_o, loop_sense_en_o}) |-> cs_n_i)
        else $error("diagnostic mode changed while selected");
    a_diag_single: assert property ($onehot0({continuity_test_o,
        loop_force_en_o, loop_sense_en_o}))
        else $error("two diagnostic modes active");
    a_enable_cut: assert property ((!fire_enable_pair_one_i && !latch_hold_i) [*6]
        |=> {squib_high_pin_o[1:0], squib_low_pin_o[1:0]} == 4'h0)
        else $error("pair one driven without enable");
    a_thermal_cut: assert property (thermal_shutdown_i [*6]
        |=> {squib_high_pin_o, squib_low_pin_o} == 8'h00)
        else $error("drivers on during thermal shutdown");
    a_low_first: assert property ((squib_high_pin_o & ~$past(squib_high_pin_o)
        & ~$past(squib_low_pin_o)) == 4'h0)
        else $error("high side on before low side");
endmodule

// [tb/squib_host_model.sv]
// Host serial master model for the command link
`timescale 1ns/10ps
module squib_host_model (
    input wire sys_clk_i,
    input wire miso_i,
    output logic sclk_o,
    output logic cs_n_o,
    output logic mosi_o
);
    // Idle link at time zero
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end

    // Wait n system clocks, moving on falling edges
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask

    // One frame of n bits with the reply gathered
    task automatic frame(input logic [7:0] tx, input int n,
        input logic alt, output logic [7:0] rx);
        int i;
        rx = 8'h00;
        sclk_o = alt; // Idle level picks the mode
        tick(4);
        cs_n_o = 1'b0;
        tick(8);
        sclk_o = 1'b0; // Leading fall in alternate mode
        for (i = 0; i < n; i++) begin
            mosi_o = tx[7 - (i % 8)];
            tick(4);
            sclk_o = 1'b1;
            tick(3);
            rx = {rx[6:0], miso_i};
            tick(1);
            sclk_o = 1'b0;
        end
        tick(4);
        cs_n_o = 1'b1;
        mosi_o = ~mosi_o; // Released line shows no stale bit
        tick(12);
    endtask
endmodule

// [tb/squib_spi_command_interface_tb.sv]
// Self-checking bench for the squib serial command front end
`timescale 1ns/10ps
module squib_spi_command_interface_tb;
    logic sys_clk = 1'b0;
    logic rst_n, fen1, fen2, therm, hold, strap;
    logic [3:0] cont, sense, hi, lo;
    logic sclk, cs_n, mosi, sdo, oe_n, alt, ct, fe, se, rej;
    logic [1:0] sel;
    logic [7:0] rx;
    logic [15:0] rej_cnt = 16'h0;
    int err_total = 0;
    int compares = 0;
    int i;
    // Command byte, reply in that frame, modes after it
    logic [20:0] rows [11] = '{{8'h00, 8'h00, 5'h00},
        {8'h96, 8'h00, 5'h00}, {8'h00, 8'h69, 5'h00},
        {8'hc8, 8'h00, 5'h00}, {8'hc2, 8'h01, 5'h10},
        {8'he8, 8'h05, 5'h01}, {8'h3c, 8'h0a, 5'h00},
        {8'he1, 8'h3c, 5'h0a}, {8'hc2, 8'h00, 5'h10},
        {8'h00, 8'h05, 5'h00}, {8'h00, 8'h00, 5'h00}};

    always #10 sys_clk = ~sys_clk;

    // Count refused frames
    always @(posedge sys_clk) begin
        if (frame_reject_seen()) rej_cnt <= rej_cnt + 16'h1;
    end

    function automatic logic frame_reject_seen();
        return rej === 1'b1;
    endfunction

    squib_spi_command_interface dut (
        .sys_clk_i(sys_clk), .rst_n_i(rst_n), .sclk_i(sclk),
        .cs_n_i(cs_n), .mosi_i(mosi), .fire_enable_pair_one_i(fen1),
        .fire_enable_pair_two_i(fen2),
        .low_side_continuity_check_i(cont), .loop_short_sense_i(sense),
        .thermal_shutdown_i(therm), .latch_hold_i(hold),
        .two_channel_strap_i(strap), .serial_data_output_o(sdo),
        .serial_data_output_oe_n_o(oe_n), .alternate_serial_mode_o(alt),
        .squib_high_pin_o(hi), .squib_low_pin_o(lo),
        .continuity_test_o(ct), .loop_force_en_o(fe),
        .loop_force_sel_o(sel), .loop_sense_en_o(se),
        .frame_reject_o(rej)
    );

    squib_host_model host (
        .sys_clk_i(sys_clk), .miso_i(oe_n ? ~sdo : sdo), // Floating line
        .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi)
    );

    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        if (err_total == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Full eight-bit frame in standard mode
    task automatic x(input logic [7:0] tx);
        host.frame(tx, 8, 1'b0, rx);
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // Hang guard
    initial begin
        repeat (60000) @(posedge sys_clk);
        err_total++;
        print_verdict();
    end

    // Main sequence
    initial begin
        {rst_n, fen1, fen2, therm, hold, strap} = 6'b010000;
        cont = 4'h5;
        sense = 4'ha;
        wait_clk(10);
        rst_n = 1'b1;
        wait_clk(4);
        for (i = 0; i < 11; i++) begin
            x(rows[i][20:13]);
            check({rx, 3'h0, ct, fe, sel, se}, {rows[i][12:5], 3'h0, rows[i][4:0]});
        end
        // Continuity held after the pins change, cleared by next frame
        x(8'hc2);
        cont = 4'h0;
        x(8'hc2);
        check({8'h0, rx}, 16'h0005);
        x(8'h00);
        check({8'h0, rx}, 16'h0000);
        cont = 4'h5;
        // Short and long frames leave the pending reply
        x(8'h96);
        host.frame(8'h00, 7, 1'b0, rx);
        host.frame(8'h00, 9, 1'b0, rx);
        x(8'h00);
        check({rx, rej_cnt[7:0]}, {8'h69, 8'h02});
        // Alternate mode frame
        host.frame(8'h96, 8, 1'b1, rx);
        check({15'h0, alt}, 16'h0001);
        x(8'h00);
        check({rx, 7'h0, alt}, {8'h69, 8'h00});
        // Arm all with only pair one enabled, then fire
        x(8'ha2);
        x(8'h5f);
        check({rx, hi, lo}, {8'ha2, 4'h3, 4'h3});
        x(8'ha0);
        x(8'h50);
        check({rx, hi, lo}, {8'ha0, 4'h3, 4'h3});
        fen1 = 1'b0;
        wait_clk(10);
        check({8'h0, hi, lo}, 16'h0000);
        fen2 = 1'b1;
        // Nibble mismatch, then a frame between arm and fire
        x(8'ha1);
        x(8'h4c);
        check({8'h0, hi, lo}, 16'h0000);
        x(8'ha1);
        x(8'h00);
        x(8'h5c);
        check({8'h0, hi, lo}, 16'h0000);
        x(8'ha1);
        x(8'h5c);
        check({8'h0, hi, lo}, 16'h00cc);
        therm = 1'b1;
        wait_clk(10);
        check({8'h0, hi, lo}, 16'h0000);
        therm = 1'b0;
        x(8'ha1);
        x(8'h5c);
        // Latch-and-hold keeps pair two on without its enable
        {hold, fen2, strap} = 3'b101;
        wait_clk(10);
        check({8'h0, hi, lo}, 16'h00cc);
        // Reset in mid-run clears drivers and reply
        rst_n = 1'b0;
        wait_clk(10);
        check({3'h0, hi, lo, oe_n, sdo, ct, fe, se}, 16'h0010);
        rst_n = 1'b1;
        wait_clk(4);
        x(8'h00);
        check({8'h0, rx}, 16'h0000);
        // Strap caught in reset shows as the status top bit
        x(8'hc8);
        x(8'h00);
        check({8'h0, rx}, 16'h0080);
        print_verdict();
    end
endmodule

bind squib_spi_command_interface squib_checker chk (.*);
